// file: verilog/pixclk_pkg.sv
package pixclk_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DIV_LOW  = 8'h00;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h04;
  localparam logic [7:0] OFF_POST_DIV = 8'h08;
  localparam logic [7:0] OFF_DELAY    = 8'h0c;
  localparam logic [7:0] OFF_PUMP     = 8'h10;
  localparam logic [7:0] OFF_OUT_CTL  = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;

  // field positions
  localparam int DLY_FINE_LSB   = 0;
  localparam int DLY_COARSE_LSB = 8;
  localparam int PC_CUR_LSB     = 0;
  localparam int PC_DET_POL     = 2;
  localparam int OC_SYNC_EDGE   = 0;
  localparam int OC_DELAYED_SYNC_POLARITY   = 1;
  localparam int OC_CLK_EN      = 2;
  localparam int OC_CLKN_EN     = 3;
  localparam int OC_HALF_EN     = 4;
  localparam int OC_HALFN_EN    = 5;
  localparam int OC_DELAYED_SYNC_OUT_EN    = 6;
  localparam int ST_RUN         = 0;
  localparam int ST_DELAYED_SYNC_OUT       = 1;
  localparam int ST_FB_LSB      = 16;

  // reset values
  localparam logic [3:0] DIV_HIGH_RST = 4'h0;
  localparam logic [7:0] DIV_LOW_RST  = 8'hff;
  localparam logic [1:0] POST_RST     = 2'h0;
  localparam logic [4:0] FINE_RST     = 5'h00;
  localparam logic [1:0] COARSE_RST   = 2'h0;
  localparam logic [2:0] PUMP_RST     = 3'h4;
  localparam logic [6:0] OUT_CTL_RST  = 7'h7f;

  // post-divider and pump codes
  localparam logic [1:0] POST_DIV1 = 2'h0;
  localparam logic [1:0] POST_DIV2 = 2'h2;
  localparam logic [1:0] POST_DIV4 = 2'h3;
  localparam logic [1:0] PUMP_LOW  = 2'h0;
  localparam logic [1:0] PUMP_MID  = 2'h2;
  localparam logic [1:0] PUMP_HIGH = 2'h3;
  localparam logic [10:0] PUMP_UA_LOW  = 11'h064;
  localparam logic [10:0] PUMP_UA_MID  = 11'h190;
  localparam logic [10:0] PUMP_UA_HIGH = 11'h640;

  // oscillator model: one period is sixteen pclk cycles, one pclk per sixteenth
  localparam int OSC_W      = 4;
  localparam int PHASE_W    = 7;
  localparam int SYNC_LOSS_US = 200;
  localparam int CLK_NS       = 4;
  localparam int SYNC_LOSS_CYC = (SYNC_LOSS_US * 1000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_WAIT = 2'b01,
    DS_HIGH = 2'b10
  } delayed_sync_out_state_t;
endpackage

// file: verilog/edge_phase_detector.sv
`timescale 1ns/1ps
module edge_phase_detector
  import pixclk_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_in,
  input  wire logic sync_edge_select,
  input  wire logic detector_polarity,
  input  wire logic fb_pulse,
  output logic      ref_edge,
  output logic      pump_up,
  output logic      pump_dn
);
  logic sync_prev_r;
  logic up_r;
  logic dn_r;
  wire  rise   = sync_in & ~sync_prev_r;
  wire  fall   = ~sync_in & sync_prev_r;
  wire  up_set = up_r | ref_edge;
  wire  dn_set = dn_r | fb_pulse;
  // only edges are compared, so a stuck level adds no reference edge and the pump holds its last state until the next edge
  assign ref_edge = sync_edge_select ? rise : fall;
  assign pump_up  = detector_polarity ? up_r : dn_r;
  assign pump_dn  = detector_polarity ? dn_r : up_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev_r <= 1'b0;
      up_r        <= 1'b0;
      dn_r        <= 1'b0;
    end else begin
      sync_prev_r <= sync_in;
      up_r        <= up_set & ~dn_set;
      dn_r        <= dn_set & ~up_set;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ref_edge_sel: assert property (
    $fell(sync_in) && !sync_edge_select |-> ref_edge)
    else $error("falling edge not taken as reference");
  a_pump_on_edge: assert property (
    ref_edge && !fb_pulse && !dn_r |=> up_r && !dn_r)
    else $error("reference edge did not raise pump up");
endmodule

// file: verilog/feedback_counter.sv
`timescale 1ns/1ps
module feedback_counter
  import pixclk_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        osc_tick,
  input  wire logic [11:0] feedback_divide_word,
  output logic             fb_pulse,
  output logic [12:0]      count
);
  logic [11:0] active_r;
  logic [12:0] count_r;
  wire  [12:0] ratio_m1 = 13'({active_r[11:3], 3'h0}) + 13'(active_r[2:0]) + 13'h007;
  wire  [12:0] next_m1  = 13'({feedback_divide_word[11:3], 3'h0})
                        + 13'(feedback_divide_word[2:0]) + 13'h007;
  wire         at_zero  = (count_r == 13'h0000);
  assign fb_pulse = osc_tick & at_zero;
  assign count    = count_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= {DIV_HIGH_RST, DIV_LOW_RST};
      count_r  <= 13'h0000;
    end else if (osc_tick) begin
      if (at_zero) begin
        active_r <= feedback_divide_word;
        count_r  <= next_m1;
      end else begin
        count_r  <= count_r - 13'h0001;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fb_reload: assert property (
    osc_tick && at_zero |=> count_r == ratio_m1)
    else $error("feedback count reloaded with wrong ratio");
  a_fb_hold_word: assert property (
    !(osc_tick && at_zero) |=> $stable(active_r))
    else $error("divide word applied before counter reached zero");
endmodule

// file: verilog/line_locked_pixel_clock_gen.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - sync edge select 1 locks to rising sync edge, 0 to falling
// - oscillator stops when sync pulses stop arriving
// - phase detector compares reference and feedback on edges only
// - pump code 00/10/11 gives 100/400/1600 microamps
// - post-divider code 00/10/11 divides oscillator by 1/2/4
// - feedback counter takes a 12-bit setting, ratios 8 to 4103
// - ratio is (m+1)*8+n, n bits 0-2, m bits 3-11
// - new divide value loads only when the counter reaches zero
// - clock output delayed by (code+1)/16 period, five-bit code
// - delayed sync fine delay is (code+1)/16 period, codes 0 to 19
// - coarse delay of 1 to 4 periods added for delayed sync
// - delayed sync leading edge timed from divided clock, usable as reset; the code counts it from the sync reference edge
// - delayed sync trailing edge timed from the clock, one-clock uncertainty
// - half-rate clock divides output clock by two, reset by delayed sync
// - normal and inverted clock outputs, TTL clock switched by its bit
// - odd and even half-rate outputs, each TTL with its own enable
// - delayed sync polarity bit 1 high-active, 0 low-active, TTL disable
module line_locked_pixel_clock_gen
  import pixclk_pkg::*;
#(
  parameter int SYNC_LOSS_CYCLES = SYNC_LOSS_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_in,
  output logic             pump_up,
  output logic             pump_dn,
  output logic [10:0]      pump_current_ua,
  output logic             clk_out,
  output logic             clk_out_n,
  output logic             clk_ttl,
  output logic             clk_n_ttl,
  output logic             half_clk_odd,
  output logic             half_clk_even,
  output logic             half_odd_ttl,
  output logic             half_even_ttl,
  output logic             delayed_sync_out,
  output logic             delayed_sync_ttl
);
  logic [3:0]   divide_high_reg;
  logic [7:0]   divide_low_reg;
  logic [1:0]   post_divider_reg;
  logic [1:0]   post_active_r;
  logic [4:0]   fine_r;
  logic [1:0]   coarse_r;
  logic [2:0]   pump_reg;
  logic [6:0]   out_ctl_r;
  logic [31:0]  prdata_r;
  logic         osc_run_r;
  logic [31:0]  loss_cnt_r;
  logic [5:0]   pcnt_r;
  logic [8:0]   ds_cnt_r;
  delayed_sync_out_state_t ds_state_r;
  delayed_sync_out_state_t ds_state_nxt;
  logic         delayed_sync_out_lvl_r;
  logic         half_r;
  logic         clk_r;
  logic [6:0]   ttl_r;
  logic         ref_edge;
  logic         fb_pulse;
  logic [12:0]  fb_count;

  // apb decode: zero wait states, unmapped addresses answer with pslverr
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire hit     = (paddr == OFF_DIV_LOW) | (paddr == OFF_DIV_HIGH) | (paddr == OFF_POST_DIV)
               | (paddr == OFF_DELAY) | (paddr == OFF_PUMP) | (paddr == OFF_OUT_CTL)
               | (paddr == OFF_STATUS);
  wire wr_low  = wr & (paddr == OFF_DIV_LOW);
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_r;

  wire sync_edge_select      = out_ctl_r[OC_SYNC_EDGE];
  wire delayed_sync_polarity = out_ctl_r[OC_DELAYED_SYNC_POLARITY];
  wire detector_polarity     = pump_reg[PC_DET_POL];
  wire [1:0] pump_code       = pump_reg[PC_CUR_LSB +: 2];
  wire [11:0] feedback_divide_value = {divide_high_reg, divide_low_reg};

  // read mux
  wire [31:0] status_word = {3'h0, fb_count, 14'h0000, delayed_sync_out_lvl_r, osc_run_r};
  wire [31:0] rd_mux =
      (paddr == OFF_DIV_LOW)  ? {24'h000000, divide_low_reg} :
      (paddr == OFF_DIV_HIGH) ? {28'h0000000, divide_high_reg} :
      (paddr == OFF_POST_DIV) ? {30'h00000000, post_divider_reg} :
      (paddr == OFF_DELAY)    ? {22'h000000, coarse_r, 3'h0, fine_r} :
      (paddr == OFF_PUMP)     ? {29'h00000000, pump_reg} :
      (paddr == OFF_OUT_CTL)  ? {25'h0000000, out_ctl_r} :
      (paddr == OFF_STATUS)   ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_high_reg  <= DIV_HIGH_RST;
      divide_low_reg   <= DIV_LOW_RST;
      post_divider_reg <= POST_RST;
      post_active_r    <= POST_RST;
      fine_r           <= FINE_RST;
      coarse_r         <= COARSE_RST;
      pump_reg         <= PUMP_RST;
      out_ctl_r        <= OUT_CTL_RST;
      prdata_r         <= 32'h00000000;
    end else begin
      if (setup && !pwrite) prdata_r <= rd_mux;
      if (wr && paddr == OFF_DIV_HIGH) divide_high_reg <= pwdata[3:0];
      if (wr && paddr == OFF_POST_DIV) post_divider_reg <= pwdata[1:0];
      if (wr && paddr == OFF_DELAY) begin
        fine_r   <= pwdata[DLY_FINE_LSB +: 5];
        coarse_r <= pwdata[DLY_COARSE_LSB +: 2];
      end
      if (wr && paddr == OFF_PUMP) pump_reg <= pwdata[2:0];
      if (wr && paddr == OFF_OUT_CTL) out_ctl_r <= pwdata[6:0];
      if (wr_low) begin
        divide_low_reg <= pwdata[7:0];
        post_active_r  <= post_divider_reg;
      end
    end
  end

  // charge pump current; the undocumented code 01 falls back to the lowest
  assign pump_current_ua = (pump_code == PUMP_HIGH) ? PUMP_UA_HIGH :
                           (pump_code == PUMP_MID)  ? PUMP_UA_MID : PUMP_UA_LOW;

  // post-divider as a shift of the sixteen-step period
  wire [1:0] shift = (post_active_r == POST_DIV4) ? 2'h2 :
                     (post_active_r == POST_DIV2) ? 2'h1 : 2'h0;
  wire [6:0] period = 7'(16) << shift;
  wire [5:0] mask   = 6'(period - 7'h01);
  wire [6:0] fine_d = 7'({2'h0, fine_r} + 7'h01) << shift;
  wire [6:0] dphase = 7'({1'b0, pcnt_r} - fine_d) & {1'b0, mask};
  wire       clk_nxt  = osc_run_r & ~dphase[OSC_W - 1 + shift];
  wire       clk_rise = osc_run_r & (dphase == 7'h00);
  wire       osc_tick = osc_run_r & (pcnt_r == 6'h00);
  wire [8:0] ds_delay = 9'(fine_d) + (9'({7'h00, coarse_r} + 9'h001) << (OSC_W + shift));
  wire       lead     = (ds_state_r == DS_WAIT) & (ds_cnt_r == 9'h001);
  wire       sync_idle = sync_edge_select ? ~sync_in : sync_in;

  // sync loss watchdog stops the oscillator model
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_r  <= 1'b0;
      loss_cnt_r <= 32'h00000000;
      pcnt_r     <= 6'h00;
    end else begin
      if (ref_edge) begin
        osc_run_r  <= 1'b1;
        loss_cnt_r <= 32'h00000000;
      end else if (loss_cnt_r >= 32'(SYNC_LOSS_CYCLES - 1)) begin
        osc_run_r  <= 1'b0;
      end else begin
        loss_cnt_r <= loss_cnt_r + 32'h00000001;
      end
      pcnt_r <= osc_run_r ? ((pcnt_r + 6'h01) & mask) : 6'h00;
    end
  end

  edge_phase_detector u_pd (
    .pclk              (pclk),
    .presetn           (presetn),
    .sync_in           (sync_in),
    .sync_edge_select  (sync_edge_select),
    .detector_polarity (detector_polarity),
    .fb_pulse          (fb_pulse),
    .ref_edge          (ref_edge),
    .pump_up           (pump_up),
    .pump_dn           (pump_dn)
  );

  feedback_counter u_fb (
    .pclk                 (pclk),
    .presetn              (presetn),
    .osc_tick             (osc_tick),
    .feedback_divide_word (feedback_divide_value),
    .fb_pulse             (fb_pulse),
    .count                (fb_count)
  );

  // delayed sync: counted in sixteenths, leading edge a fixed count after the reference edge
  always_comb begin
    ds_state_nxt = ds_state_r;
    case (ds_state_r)
      DS_IDLE: if (ref_edge && osc_run_r) ds_state_nxt = DS_WAIT;
      DS_WAIT: if (lead) ds_state_nxt = DS_HIGH;
      DS_HIGH: if (clk_rise && sync_idle) ds_state_nxt = DS_IDLE;
      default: ds_state_nxt = DS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_state_r  <= DS_IDLE;
      ds_cnt_r    <= 9'h000;
      delayed_sync_out_lvl_r <= 1'b0;
      half_r      <= 1'b0;
    end else begin
      ds_state_r  <= ds_state_nxt;
      ds_cnt_r    <= (ds_state_r == DS_IDLE) ? ds_delay : ds_cnt_r - 9'h001;
      delayed_sync_out_lvl_r <= (ds_state_nxt == DS_HIGH);
      // resetting the divider here keeps odd/even phase tied to the line start
      if (lead) half_r <= 1'b0;
      else if (clk_rise) half_r <= ~half_r;
    end
  end

  // output flops; a disabled ttl output is held low
  wire ds_pol_lvl = delayed_sync_polarity ? delayed_sync_out_lvl_r : ~delayed_sync_out_lvl_r;
  wire [6:0] ttl_nxt = {
    out_ctl_r[OC_DELAYED_SYNC_OUT_EN] & ds_pol_lvl,
    out_ctl_r[OC_HALFN_EN] & ~half_r,
    out_ctl_r[OC_HALF_EN]  & half_r,
    out_ctl_r[OC_CLKN_EN]  & ~clk_nxt,
    out_ctl_r[OC_CLK_EN]   & clk_nxt,
    ds_pol_lvl,
    half_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_r <= 1'b0;
      ttl_r <= 7'h00;
    end else begin
      clk_r <= clk_nxt;
      ttl_r <= ttl_nxt;
    end
  end

  assign clk_out          = clk_r;
  assign clk_out_n        = ~clk_r;
  assign half_clk_odd     = ttl_r[0];
  assign half_clk_even    = ~ttl_r[0];
  assign delayed_sync_out = ttl_r[1];
  assign clk_ttl          = ttl_r[2];
  assign clk_n_ttl        = ttl_r[3];
  assign half_odd_ttl     = ttl_r[4];
  assign half_even_ttl    = ttl_r[5];
  assign delayed_sync_ttl = ttl_r[6];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lead;
    ds_state_r == DS_WAIT && ds_cnt_r == 9'h001;
  endsequence
  sequence s_lead_out;
    delayed_sync_out_lvl_r && !half_r;
  endsequence

  a_osc_stops: assert property (
    !osc_run_r && !ref_edge |=> !osc_run_r ##1 !clk_out && pcnt_r == 6'h00)
    else $error("oscillator ran without sync");
  a_pump_current: assert property (
    pump_code == PUMP_MID |-> pump_current_ua == PUMP_UA_MID)
    else $error("pump current wrong for mid code");
  a_post_period: assert property (
    osc_run_r && post_active_r == POST_DIV4 && pcnt_r == 6'h1f |=> pcnt_r == 6'h20)
    else $error("post-divided period wrong");
  a_clk_delay: assert property (
    clk_rise |=> clk_out ##0 $past(dphase) == 7'h00)
    else $error("delayed clock did not rise at its phase");
  a_delayed_sync_out_lead: assert property (
    s_lead |=> s_lead_out)
    else $error("delayed sync lead or half clock reset missing");
  a_delayed_sync_out_total: assert property (
    ds_state_r == DS_IDLE && ref_edge && osc_run_r && coarse_r == 2'h3 && fine_r == 5'h13
      && post_active_r == POST_DIV1 |=> ds_cnt_r == 9'h054)
    else $error("delayed sync delay count wrong");
  a_delayed_sync_polarity: assert property (
    !delayed_sync_polarity && $stable(delayed_sync_polarity) && delayed_sync_out_lvl_r |=> !delayed_sync_out)
    else $error("low-active delayed sync not low");
  a_ttl_off: assert property (
    !out_ctl_r[OC_CLK_EN] |=> !clk_ttl)
    else $error("ttl clock output not off");
  a_commit_post: assert property (
    wr_low |=> post_active_r == $past(post_divider_reg))
    else $error("post divider not committed with low divide write");
endmodule

// file: sim/sync_source.sv
`timescale 1ns/1ps
module sync_source #(
  parameter int PERIOD = 300,
  parameter int WIDTH  = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic active_high,
  output logic      sync_in
);
  int phase;

  // a stopped source parks the line at its inactive level, so no stray edge reaches the detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase   <= 0;
      sync_in <= 1'b0;
    end else begin
      phase   <= (run && phase < PERIOD - 1) ? phase + 1 : 0;
      sync_in <= (run && phase < WIDTH) ? active_high : ~active_high;
    end
  end
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import pixclk_pkg::*;
;
  localparam int LOSS  = 400;
  localparam int LIMIT = 60000;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_in;
  logic        pump_up;
  logic        pump_dn;
  logic [10:0] pump_current_ua;
  logic        clk_out;
  logic        clk_out_n;
  logic        clk_ttl;
  logic        clk_n_ttl;
  logic        half_clk_odd;
  logic        half_clk_even;
  logic        half_odd_ttl;
  logic        half_even_ttl;
  logic        delayed_sync_out;
  logic        delayed_sync_ttl;
  logic        src_run;
  logic        src_high;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int          fail_count;
  int          compares;
  int          cycles;
  logic [31:0] seed;
  logic [7:0]  rst_addr [6] = '{OFF_DIV_LOW, OFF_DIV_HIGH, OFF_POST_DIV, OFF_DELAY, OFF_PUMP,
                                OFF_OUT_CTL};
  logic [31:0] rst_val  [6] = '{32'hff, 32'h0, 32'h0, 32'h0, 32'h4, 32'h7f};
  logic [1:0]  pump_code [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [10:0] pump_ua   [4] = '{11'h064, 11'h190, 11'h640, 11'h064};
  logic [1:0]  post_code [4] = '{POST_DIV2, POST_DIV4, POST_DIV1, POST_DIV1};
  int          post_d    [4] = '{2, 4, 1, 1};
  int          fine_v    [4] = '{5, 0, 19, 1};
  int          coarse_v  [4] = '{1, 2, 3, 0};

  sync_source u_src (.pclk(pclk), .presetn(presetn), .run(src_run), .active_high(src_high),
                     .sync_in(sync_in));

  line_locked_pixel_clock_gen #(.SYNC_LOSS_CYCLES(LOSS)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .pump_up(pump_up), .pump_dn(pump_dn), .pump_current_ua(pump_current_ua),
    .clk_out(clk_out), .clk_out_n(clk_out_n), .clk_ttl(clk_ttl), .clk_n_ttl(clk_n_ttl),
    .half_clk_odd(half_clk_odd), .half_clk_even(half_clk_even), .half_odd_ttl(half_odd_ttl),
    .half_even_ttl(half_even_ttl), .delayed_sync_out(delayed_sync_out),
    .delayed_sync_ttl(delayed_sync_ttl));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one idle cycle between transfers keeps every strobe to a single assignment per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge pclk);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  task automatic set_div(input logic [11:0] w, input logic [1:0] post);
    wr(OFF_DIV_HIGH, {28'h0, w[11:8]});
    wr(OFF_POST_DIV, {30'h0, post});
    wr(OFF_DIV_LOW, {24'h0, w[7:0]});
  endtask

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      check({pslverr, prdata} & msk_q[0], exp_q[0], "apb");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end

  // cycles from the leading sync edge to the active edge of the delayed sync
  task automatic measure(input logic spol, input logic dpol, output int n, output logic h);
    logic prev;
    int   g;
    g = 0;
    n = 0;
    prev = sync_in;
    @(posedge pclk);
    while (!(prev !== spol && sync_in === spol) && g < 1000) begin
      prev = sync_in;
      @(posedge pclk);
      g++;
    end
    prev = delayed_sync_out;
    while (!(prev !== dpol && delayed_sync_out === dpol) && n < 1000) begin
      prev = delayed_sync_out;
      @(posedge pclk);
      n++;
    end
    h = half_clk_odd;
  endtask

  task automatic line_delay(input logic spol, input logic dpol, output int n);
    logic h1;
    logic h2;
    measure(spol, dpol, n, h1);
    measure(spol, dpol, n, h1);
    measure(spol, dpol, n, h2);
    check({32'h0, h1}, {32'h0, h2}, "half phase at delayed sync");
    check({32'h0, h2}, 33'h0, "half clock not reset by delayed sync");
  endtask

  initial begin
    int          base;
    int          n;
    logic [4:0]  seen;
    logic        bad;
    logic [1:0]  pmp;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_run = 1'b0;
    src_high = 1'b1;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    seed = 32'hb4bce447;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(rst_addr[i], rst_val[i], 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hffffffff});
    apb(1'b1, 8'h1c, 32'h5, {1'b1, 32'h0}, 33'h1_0000_0000);
    wr(OFF_STATUS, 32'hffffffff);
    rd(OFF_STATUS, 32'h0, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PUMP, {29'h0, 1'b1, pump_code[i]});
      @(posedge pclk);
      check({22'h0, pump_current_ua}, {22'h0, pump_ua[i]}, "pump current");
    end
    wr(OFF_PUMP, 32'h4);
    src_run <= 1'b1;
    repeat (700) @(posedge pclk);
    rd(OFF_STATUS, 32'h1, 32'h1);
    set_div(12'h0ff, POST_DIV1);
    wr(OFF_DELAY, 32'h0);
    line_delay(1'b1, 1'b1, base);
    // one sixteenth plus one period, then two output flop stages
    check(33'(base), 33'(1 + 16 + 2), "base delayed sync delay");
    for (int i = 0; i < 4; i++) begin
      set_div(12'h0ff, post_code[i]);
      wr(OFF_DELAY, {22'h0, 2'(coarse_v[i]), 3'h0, 5'(fine_v[i])});
      line_delay(1'b1, 1'b1, n);
      check(33'(n - base),
            33'((fine_v[i] + 1) * post_d[i] + (coarse_v[i] + 1) * 16 * post_d[i] - 17),
            "delayed sync delay");
    end
    set_div(12'h0ff, POST_DIV1);
    wr(OFF_DELAY, 32'h0);
    src_high <= 1'b0;
    wr(OFF_OUT_CTL, 32'h7c);
    line_delay(1'b0, 1'b0, n);
    check(33'(n), 33'(base), "falling edge lock");
    src_high <= 1'b1;
    pmp = 2'b00;
    for (int k = 0; k < 3; k++) begin
      seed = xorshift(seed);
      wr(OFF_OUT_CTL, {25'h0, seed[6:2], 2'b11});
      repeat (2) @(posedge pclk);
      seen = 5'h0;
      bad = 1'b0;
      repeat (700) begin
        @(posedge pclk);
        seen |= {delayed_sync_ttl, half_even_ttl, half_odd_ttl, clk_n_ttl, clk_ttl};
        bad |= (clk_out_n !== ~clk_out) || (half_clk_even !== ~half_clk_odd);
        pmp[0] |= pump_up;
      end
      check({28'h0, seen}, {28'h0, seed[6:2]}, "ttl enables");
      check({32'h0, bad}, 33'h0, "complement outputs");
    end
    // every line's reference edge raises pump up long before the slow feedback pulse
    check({32'h0, pmp[0]}, 33'h1, "pump up after reference edge");
    wr(OFF_PUMP, 32'h0);
    repeat (400) begin
      @(posedge pclk);
      pmp[1] |= pump_dn;
    end
    check({32'h0, pmp[1]}, 33'h1, "pump not swapped by detector polarity");
    wr(OFF_PUMP, 32'h4);
    // stopping the source must let the oscillator die after the loss window
    src_run <= 1'b0;
    repeat (LOSS + 200) @(posedge pclk);
    rd(OFF_STATUS, 32'h0, 32'h1);
    bad = 1'b0;
    repeat (40) begin
      @(posedge pclk);
      bad |= (clk_out !== 1'b0);
    end
    check({32'h0, bad}, 33'h0, "clock stopped");
    repeat (4) @(posedge pclk);
    conclude();
  end
endmodule
